// ---- tarp_top.sv ----
// Touch ADC result path: AHB-Lite registers, touch FIFO, filter, interval counters.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - Aux ready flag reads 1 when active; writing 1 clears it.
// - Same-point interval register times repeat samples on the 10us tick.
// - Pen-wait interval register times pen-down wait and point spacing.
// - Touch samples sit in a two-word 32-bit FIFO behind one register.
// - Low sample bits 11:0 tag 15; high sample bits 27:16 tag 31.
// - Writing touch, battery or aux result register clears its data.
// - Tags show the Z pair in four-measure mode, zero otherwise.
// - Three-measure mode gives word Y:X then word 0:Z; both read.
// - Four-measure mode gives Y:X then Z2:Z1 or Z4:Z3.
// - Two-measure mode gives one word Y:X with zero tags.
// - Battery result holds 12 bits, upper bits read zero.
// - Aux result holds 12 bits, upper bits read zero.
// - Reserved bits read zero and ignore writes.
// - Filter register has enable at bit 15 and threshold 11:0.
// - Filter zeroes X, Y and Z pair in four-measure mode when Z difference exceeds threshold.
// - No new point is taken until the FIFO is fully read or cleared by a write.
// - Touch ready flag rises when a point is available.
// - Interval registers are 16 bits and reset to zero.
module tarp_top (
  // Clock, reset and enable.
  input  wire logic               sys_clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic               ce_in,
  // AHB-Lite slave.
  input  wire logic               hsel_in,
  input  wire logic [31:0]        haddr_in,
  input  wire logic [1:0]         htrans_in,
  input  wire logic               hwrite_in,
  input  wire logic [2:0]         hsize_in,
  input  wire logic [31:0]        hwdata_in,
  input  wire logic               hready_in,
  output logic      [31:0]        hrdata_out,
  output logic                    hreadyout_out,
  output logic                    hresp_out,
  // Converter channels.
  input  wire tarp_pkg::tarp_point_t point_in,
  input  wire logic               point_valid_in,
  output logic                    point_ready_out,
  input  wire tarp_pkg::tarp_conv_t bat_in,
  input  wire tarp_pkg::tarp_conv_t aux_in,
  // Rest of the unit.
  input  wire logic [1:0]         interval_start_in,
  output logic      [1:0]         interval_done_out,
  output tarp_pkg::tarp_mode_t    mode_out,
  output logic                    drive_select_out,
  output logic                    touch_ready_out,
  output logic                    bat_ready_out,
  output logic                    aux_ready_out
);
  localparam int SW = tarp_pkg::SAMPLE_W;

  // Bus phase state.
  tarp_pkg::tarp_bus_state_t st, next_st;
  logic       wr_q, next_wr_q;
  logic [7:0] addr_q, next_addr_q;
  logic       rdy, next_rdy;

  // Registers and FIFO.
  logic [15:0] same_q, next_same_q, wait_q, next_wait_q;
  logic [SW-1:0] bat_q, next_bat_q, aux_q, next_aux_q, thr_q, next_thr_q;
  logic        flt_on, next_flt_on;
  tarp_pkg::tarp_mode_t mode_q, next_mode_q;
  logic        drv_q, next_drv_q;
  logic        f_tch, next_f_tch, f_bat, next_f_bat, f_aux, next_f_aux;
  logic [31:0] fifo [tarp_pkg::FIFO_DEPTH];
  logic [31:0] next_fifo [tarp_pkg::FIFO_DEPTH];
  logic [1:0]  cnt, next_cnt;
  logic        prdy, next_prdy;
  logic [31:0] rdata, next_rdata;

  // Tick divider.
  logic [8:0]  tick_cnt, next_tick_cnt;
  logic        tick, next_tick;

  // Decoded strobes of the current data phase.
  logic        wr_act, rd_act, take_pt, reject;
  logic [SW-1:0] zdiff;
  logic [31:0] w0, w1;

  assign wr_act  = (st == tarp_pkg::TARP_BUS_DATA) && wr_q;
  assign rd_act  = (st == tarp_pkg::TARP_BUS_DATA) && !wr_q;
  assign take_pt = point_valid_in && prdy;
  assign zdiff   = (point_in.z_hi > point_in.z_lo) ? point_in.z_hi - point_in.z_lo
                                                   : point_in.z_lo - point_in.z_hi;
  assign reject  = flt_on && (mode_q == tarp_pkg::TARP_MODE_XYZZ) && (zdiff > thr_q);

  // Words formed from an incoming point; the filter blanks samples but keeps tags.
  always_comb begin
    logic tag;
    tag = (mode_q == tarp_pkg::TARP_MODE_XYZZ) && point_in.pair_z12;
    w0 = tarp_pkg::RST_WORD;
    w1 = tarp_pkg::RST_WORD;
    w0[tarp_pkg::HI_TAG_BIT] = tag;
    w0[tarp_pkg::LO_TAG_BIT] = tag;
    w1[tarp_pkg::HI_TAG_BIT] = tag;
    w1[tarp_pkg::LO_TAG_BIT] = tag;
    if (!reject) begin
      w0[tarp_pkg::LO_DATA_POS +: SW] = point_in.x;
      w0[tarp_pkg::HI_DATA_POS +: SW] = point_in.y;
      w1[tarp_pkg::LO_DATA_POS +: SW] = point_in.z_lo;
      if (mode_q == tarp_pkg::TARP_MODE_XYZZ) begin
        w1[tarp_pkg::HI_DATA_POS +: SW] = point_in.z_hi;
      end
    end
  end

  // Bus phase: one wait cycle per transfer so read data comes from a flop.
  always_comb begin
    next_st     = st;
    next_wr_q   = wr_q;
    next_addr_q = addr_q;
    next_rdy    = 1'b1;
    case (st)
      tarp_pkg::TARP_BUS_IDLE: begin
        if (hsel_in && htrans_in[1] && hready_in) begin
          next_st     = tarp_pkg::TARP_BUS_DATA;
          next_wr_q   = hwrite_in;
          next_addr_q = haddr_in[7:0];
          next_rdy    = 1'b0;
        end
      end
      tarp_pkg::TARP_BUS_DATA: next_st = tarp_pkg::TARP_BUS_IDLE;
      default: next_st = tarp_pkg::TARP_BUS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st     <= tarp_pkg::TARP_BUS_IDLE;
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
      rdy    <= 1'b1;
    end else if (ce_in) begin
      st     <= next_st;
      wr_q   <= next_wr_q;
      addr_q <= next_addr_q;
      rdy    <= next_rdy;
    end
  end

  // Registers, flags and the touch FIFO.
  always_comb begin
    next_same_q = same_q;
    next_wait_q = wait_q;
    next_bat_q  = bat_q;
    next_aux_q  = aux_q;
    next_thr_q  = thr_q;
    next_flt_on = flt_on;
    next_mode_q = mode_q;
    next_drv_q  = drv_q;
    next_f_tch  = f_tch;
    next_f_bat  = f_bat;
    next_f_aux  = f_aux;
    next_fifo   = fifo;
    next_cnt    = cnt;
    next_rdata  = rdata;
    if (wr_act) begin
      case (addr_q)
        tarp_pkg::OFS_CFG: begin
          next_drv_q  = hwdata_in[tarp_pkg::CFG_DRV_BIT];
          next_mode_q = tarp_pkg::tarp_mode_t'(hwdata_in[tarp_pkg::CFG_MODE_LO +: 2]);
        end
        tarp_pkg::OFS_STAT: begin
          next_f_tch = f_tch & ~hwdata_in[tarp_pkg::STAT_TCH_BIT];
          next_f_bat = f_bat & ~hwdata_in[tarp_pkg::STAT_BAT_BIT];
          next_f_aux = f_aux & ~hwdata_in[tarp_pkg::STAT_AUX_BIT];
        end
        tarp_pkg::OFS_SAME: next_same_q = hwdata_in[15:0];
        tarp_pkg::OFS_WAIT: next_wait_q = hwdata_in[15:0];
        tarp_pkg::OFS_TCH: begin
          next_fifo[0] = tarp_pkg::RST_WORD;
          next_fifo[1] = tarp_pkg::RST_WORD;
          next_cnt     = 2'd0;
        end
        tarp_pkg::OFS_BAT: next_bat_q = '0;
        tarp_pkg::OFS_AUX: next_aux_q = '0;
        tarp_pkg::OFS_FLT: begin
          next_flt_on = hwdata_in[tarp_pkg::FILTER_ON_BIT];
          next_thr_q  = hwdata_in[SW-1:0];
        end
        default: next_rdata = rdata;
      endcase
    end
    if (rd_act) begin
      next_rdata = tarp_pkg::RST_WORD;
      case (addr_q)
        tarp_pkg::OFS_CFG: begin
          next_rdata[tarp_pkg::CFG_DRV_BIT] = drv_q;
          next_rdata[tarp_pkg::CFG_MODE_LO +: 2] = mode_q;
        end
        tarp_pkg::OFS_STAT: begin
          next_rdata[tarp_pkg::STAT_TCH_BIT] = f_tch;
          next_rdata[tarp_pkg::STAT_BAT_BIT] = f_bat;
          next_rdata[tarp_pkg::STAT_AUX_BIT] = f_aux;
        end
        tarp_pkg::OFS_SAME: next_rdata[15:0] = same_q;
        tarp_pkg::OFS_WAIT: next_rdata[15:0] = wait_q;
        tarp_pkg::OFS_TCH: begin
          // An empty FIFO reads as zero, so a word left behind a pop never leaks out.
          if (cnt != 2'd0) begin
            next_rdata   = fifo[0];
            next_fifo[0] = fifo[1];
            next_fifo[1] = tarp_pkg::RST_WORD;
            next_cnt     = cnt - 2'd1;
          end
        end
        tarp_pkg::OFS_BAT: next_rdata[SW-1:0] = bat_q;
        tarp_pkg::OFS_AUX: next_rdata[SW-1:0] = aux_q;
        tarp_pkg::OFS_FLT: begin
          next_rdata[tarp_pkg::FILTER_ON_BIT] = flt_on;
          next_rdata[SW-1:0] = thr_q;
        end
        default: next_rdata = tarp_pkg::RST_WORD;
      endcase
    end
    // Fresh results win over a clear in the same cycle, so no event is lost.
    if (take_pt) begin
      next_fifo[0] = w0;
      next_fifo[1] = w1;
      next_cnt     = (mode_q == tarp_pkg::TARP_MODE_XY) ? 2'd1 : 2'd2;
      next_f_tch   = 1'b1;
    end
    if (bat_in.valid) begin
      next_bat_q = bat_in.data;
      next_f_bat = 1'b1;
    end
    if (aux_in.valid) begin
      next_aux_q = aux_in.data;
      next_f_aux = 1'b1;
    end
    next_prdy = (next_cnt == 2'd0);
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      same_q  <= tarp_pkg::RST_INTERVAL;
      wait_q  <= tarp_pkg::RST_INTERVAL;
      bat_q   <= '0;
      aux_q   <= '0;
      thr_q   <= '0;
      flt_on  <= 1'b0;
      mode_q  <= tarp_pkg::TARP_MODE_XY;
      drv_q   <= 1'b0;
      f_tch   <= 1'b0;
      f_bat   <= 1'b0;
      f_aux   <= 1'b0;
      fifo[0] <= tarp_pkg::RST_WORD;
      fifo[1] <= tarp_pkg::RST_WORD;
      cnt     <= 2'd0;
      prdy    <= 1'b1;
      rdata   <= tarp_pkg::RST_WORD;
    end else if (ce_in) begin
      same_q  <= next_same_q;
      wait_q  <= next_wait_q;
      bat_q   <= next_bat_q;
      aux_q   <= next_aux_q;
      thr_q   <= next_thr_q;
      flt_on  <= next_flt_on;
      mode_q  <= next_mode_q;
      drv_q   <= next_drv_q;
      f_tch   <= next_f_tch;
      f_bat   <= next_f_bat;
      f_aux   <= next_f_aux;
      fifo    <= next_fifo;
      cnt     <= next_cnt;
      prdy    <= next_prdy;
      rdata   <= next_rdata;
    end
  end

  // Free-running 10us tick; its phase is not tied to interval starts, so a wait may
  // end up to one tick late.
  always_comb begin
    next_tick     = 1'b0;
    next_tick_cnt = tick_cnt + 9'd1;
    if (tick_cnt == 9'(tarp_pkg::TICK_CYCLES - 1)) begin
      next_tick_cnt = 9'd0;
      next_tick     = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      tick_cnt <= 9'd0;
      tick     <= 1'b0;
    end else if (ce_in) begin
      tick_cnt <= next_tick_cnt;
      tick     <= next_tick;
    end
  end

  // Interval counters: index 0 same point, index 1 pen wait.
  logic [1:0][15:0] ivl_val;
  logic [1:0]       ivl_done;
  assign ivl_val[0] = same_q;
  assign ivl_val[1] = wait_q;

  for (genvar g = 0; g < 2; g++) begin : g_ivl
    logic [15:0] c, next_c;
    logic        run, next_run, done, next_done;
    always_comb begin
      next_c    = c;
      next_run  = run;
      next_done = 1'b0;
      if (interval_start_in[g]) begin
        next_c   = ivl_val[g];
        next_run = 1'b1;
      end else if (run && tick) begin
        if (c == 16'h0000) begin
          next_run  = 1'b0;
          next_done = 1'b1;
        end else begin
          next_c = c - 16'h0001;
        end
      end
    end
    always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
        c    <= tarp_pkg::RST_INTERVAL;
        run  <= 1'b0;
        done <= 1'b0;
      end else if (ce_in) begin
        c    <= next_c;
        run  <= next_run;
        done <= next_done;
      end
    end
    assign ivl_done[g] = done;
  end

  // Outputs, all from flops except hresp_out, which is tied to zero.
  assign hrdata_out        = rdata;
  assign hreadyout_out     = rdy;
  assign hresp_out         = 1'b0;
  assign point_ready_out   = prdy;
  assign interval_done_out = ivl_done;
  assign mode_out          = mode_q;
  assign drive_select_out  = drv_q;
  assign touch_ready_out   = f_tch;
  assign bat_ready_out     = f_bat;
  assign aux_ready_out     = f_aux;

  // Checks.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in || !ce_in);

  a_aux_flag_set: assert property (aux_in.valid |=> f_aux && aux_q == $past(aux_in.data))
    else $error("aux result not loaded");
  a_aux_w1c: assert property (wr_act && addr_q == tarp_pkg::OFS_STAT && hwdata_in[0] &&
    !aux_in.valid |=> !f_aux)
    else $error("aux flag not cleared");
  a_fifo_depth: assert property (cnt <= 2'd2)
    else $error("fifo over depth");
  a_ready_empty: assert property (prdy == (cnt == 2'd0))
    else $error("point ready while fifo holds data");
  a_tag_zero: assert property (take_pt && mode_q != tarp_pkg::TARP_MODE_XYZZ |=>
    !fifo[0][31] && !fifo[0][15] && !fifo[1][31])
    else $error("tag set outside four-measure mode");
  a_bat_upper: assert property (rd_act && addr_q == tarp_pkg::OFS_BAT |=>
    rdata[31:12] == 20'h0)
    else $error("battery upper bits not zero");
  a_filter_zero: assert property (take_pt && reject |=> fifo[0][27:16] == 12'h0 &&
    fifo[0][11:0] == 12'h0 && fifo[1][27:16] == 12'h0 && fifo[1][11:0] == 12'h0)
    else $error("rejected point not zeroed");
  a_xy_count: assert property (take_pt && mode_q == tarp_pkg::TARP_MODE_XY |=>
    cnt == 2'd1)
    else $error("two-measure mode not one word");
  a_bus_wait: assert property (!rdy |=> rdy ##0 st == tarp_pkg::TARP_BUS_IDLE)
    else $error("bus wait longer than one cycle");
  a_ivl_load: assert property (interval_start_in[1] |=>
    g_ivl[1].run && g_ivl[1].c == $past(wait_q))
    else $error("wait counter not reloaded");

  c_point_xyzz: cover property (take_pt && mode_q == tarp_pkg::TARP_MODE_XYZZ);
  c_fifo_drain: cover property (cnt == 2'd2 ##[1:20] cnt == 2'd0);
  c_filter_hit: cover property (take_pt && reject);
  c_ivl_done:   cover property (ivl_done[0]);
endmodule

// ---- tarp_pkg.sv ----
// Shared constants and types for the touch ADC result path.
package tarp_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CFG  = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_SAME = 8'h10;
  localparam logic [7:0] OFS_WAIT = 8'h14;
  localparam logic [7:0] OFS_TCH  = 8'h18;
  localparam logic [7:0] OFS_BAT  = 8'h1c;
  localparam logic [7:0] OFS_AUX  = 8'h20;
  localparam logic [7:0] OFS_FLT  = 8'h24;
  // Field positions.
  localparam int CFG_DRV_BIT  = 30;
  localparam int CFG_MODE_LO  = 13;
  localparam int STAT_TCH_BIT = 2;
  localparam int STAT_BAT_BIT = 1;
  localparam int STAT_AUX_BIT = 0;
  localparam int FILTER_ON_BIT   = 15;
  localparam int LO_DATA_POS  = 0;
  localparam int HI_DATA_POS  = 16;
  localparam int LO_TAG_BIT   = 15;
  localparam int HI_TAG_BIT   = 31;
  localparam int SAMPLE_W     = 12;
  localparam int FIFO_DEPTH   = 2;
  // Values after reset.
  localparam logic [15:0] RST_INTERVAL = 16'h0000;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  localparam logic [15:0] RST_HALF     = 16'h0000;
  // Interval tick timing.
  localparam int TICK_PERIOD_NS = 10000;
  localparam int CLK_PERIOD_NS  = 25;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // Touch measurement sequences.
  typedef enum logic [1:0] {
    TARP_MODE_XY   = 2'h0,
    TARP_MODE_XYZ  = 2'h1,
    TARP_MODE_XYZZ = 2'h2
  } tarp_mode_t;
  // Bus slave phase.
  typedef enum logic {TARP_BUS_IDLE, TARP_BUS_DATA} tarp_bus_state_t;
  // One touch point from the converter.
  typedef struct packed {
    logic [SAMPLE_W-1:0] x;
    logic [SAMPLE_W-1:0] y;
    logic [SAMPLE_W-1:0] z_lo;
    logic [SAMPLE_W-1:0] z_hi;
    logic                pair_z12;
  } tarp_point_t;
  // One single-channel conversion.
  typedef struct packed {
    logic                valid;
    logic [SAMPLE_W-1:0] data;
  } tarp_conv_t;
endpackage

// ---- tarp_conv_model.sv ----
// Behavioural converter channels that feed touch points and single conversions to the block.
`timescale 1ns/1ps
module tarp_conv_model (
  // Clock and reset.
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // Commands from the bench.
  input  wire logic                  send_in,
  input  wire tarp_pkg::tarp_point_t pt_in,
  input  wire logic [1:0]            conv_go_in,
  input  wire logic [11:0]           conv_data_in,
  // Towards the block.
  input  wire logic                  point_ready_in,
  output tarp_pkg::tarp_point_t      point_out,
  output logic                       point_valid_out,
  output tarp_pkg::tarp_conv_t       bat_out,
  output tarp_pkg::tarp_conv_t       aux_out
);
  // A point is offered until taken; once taken the lines flip so stale data never looks valid.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      point_valid_out <= 1'b0;
      point_out       <= '0;
    end else if (send_in) begin
      point_valid_out <= 1'b1;
      point_out       <= pt_in;
    end else if (point_valid_out && point_ready_in) begin
      point_valid_out <= 1'b0;
      point_out       <= ~point_out;
    end
  end
  // Single conversions are one-cycle pulses; idle data is the inverse of the last value.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bat_out <= '0;
      aux_out <= '0;
    end else begin
      bat_out <= {conv_go_in[0], conv_go_in[0] ? conv_data_in : ~bat_out.data};
      aux_out <= {conv_go_in[1], conv_go_in[1] ? conv_data_in : ~aux_out.data};
    end
  end
endmodule

// ---- touch_adc_result_path_tb.sv ----
// Self-checking bench for the touch ADC result path.
`timescale 1ns/1ps
module touch_adc_result_path_tb;
  logic sys_clk, sys_rst, ce, hsel, hwrite, send, point_valid, point_ready, drv;
  logic touch_rdy, bat_rdy, aux_rdy, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, istart, idone, conv_go;
  logic [2:0]  hsize;
  logic [11:0] conv_data;
  tarp_pkg::tarp_point_t point, pt;
  tarp_pkg::tarp_conv_t  bat, aux;
  tarp_pkg::tarp_mode_t  mode;
  int fail_count = 0;
  int n_checks   = 0;

  tarp_top tarp_top_i (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .ce_in(ce),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .point_in(point),
    .point_valid_in(point_valid), .point_ready_out(point_ready), .bat_in(bat), .aux_in(aux),
    .interval_start_in(istart), .interval_done_out(idone), .mode_out(mode),
    .drive_select_out(drv), .touch_ready_out(touch_rdy), .bat_ready_out(bat_rdy),
    .aux_ready_out(aux_rdy));
  tarp_conv_model tarp_conv_model_i (.clk_in(sys_clk), .rst_in(sys_rst), .send_in(send),
    .pt_in(pt), .conv_go_in(conv_go), .conv_data_in(conv_data), .point_ready_in(point_ready),
    .point_out(point), .point_valid_out(point_valid), .bat_out(bat), .aux_out(aux));

  // Free-running 40 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One single AHB-Lite transfer; the bus answer is awaited under a bound, never assumed.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "bus response");
    if (n >= 100) chk(32'h1, 32'h0, "bus answer timeout");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(a, 1'b1, d, dummy);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    bus(a, 1'b0, 32'h0, d);
    chk(d, exp, what);
  endtask

  // Waits, under a bound, for a chosen design output to reach a level; returns cycles spent.
  task automatic wait_for(input int sel, input logic val, input int lim, output int n);
    logic s;
    for (n = 0; n < lim; n++) begin
      case (sel)
        0: s = point_ready;
        1: s = touch_rdy;
        2: s = bat_rdy;
        3: s = aux_rdy;
        4: s = idone[0];
        default: s = idone[1];
      endcase
      if (s === val) break;
      @(posedge sys_clk);
    end
    chk({31'h0, s}, {31'h0, val}, "awaited output level");
  endtask

  function automatic logic [31:0] word(logic [11:0] hi, logic [11:0] lo, logic tag);
    return {tag, 3'h0, hi, tag, 3'h0, lo};
  endfunction

  // Selects a mode, clears the touch flag and offers one point with the given pair.
  task automatic offer(input logic [1:0] m, input logic pair, input logic ex);
    int n;
    wr(tarp_pkg::OFS_CFG, {1'b0, ex, 15'h0, m, 13'h0});
    wr(tarp_pkg::OFS_STAT, 32'h4);
    pt   <= '{x: 12'h123, y: 12'h456, z_lo: 12'h789, z_hi: 12'habc, pair_z12: pair};
    send <= 1'b1;
    @(posedge sys_clk);
    send <= 1'b0;
    wait_for(1, 1'b1, 20, n);
    chk({31'h0, point_ready}, 32'h0, "next point held off");
  endtask

  task automatic test_regs();
    rd_chk(tarp_pkg::OFS_SAME, 32'h0, "same interval reset");
    rd_chk(tarp_pkg::OFS_WAIT, 32'h0, "wait interval reset");
    rd_chk(8'h40, 32'h0, "unmapped read");
    wr(tarp_pkg::OFS_SAME, 32'hffff_ffff);
    rd_chk(tarp_pkg::OFS_SAME, 32'h0000_ffff, "same interval width");
    wr(tarp_pkg::OFS_FLT, 32'hffff_ffff);
    rd_chk(tarp_pkg::OFS_FLT, 32'h0000_8fff, "filter fields");
    wr(tarp_pkg::OFS_FLT, 32'h0);
    $display("test regs finished");
  endtask

  task automatic test_results();
    int n;
    conv_data <= 12'habc;
    conv_go   <= 2'b01;
    @(posedge sys_clk);
    conv_data <= 12'h5a5;
    conv_go   <= 2'b10;
    @(posedge sys_clk);
    conv_go   <= 2'b00;
    wait_for(2, 1'b1, 10, n);
    wait_for(3, 1'b1, 10, n);
    rd_chk(tarp_pkg::OFS_BAT, 32'h0000_0abc, "battery result");
    rd_chk(tarp_pkg::OFS_AUX, 32'h0000_05a5, "aux result");
    rd_chk(tarp_pkg::OFS_STAT, 32'h0000_0003, "result flags");
    wr(tarp_pkg::OFS_STAT, 32'h1);
    wait_for(3, 1'b0, 10, n);
    chk({31'h0, bat_rdy}, 32'h1, "battery flag kept");
    wr(tarp_pkg::OFS_BAT, 32'hffff_ffff);
    rd_chk(tarp_pkg::OFS_BAT, 32'h0, "battery cleared");
    wr(tarp_pkg::OFS_AUX, 32'hffff_ffff);
    rd_chk(tarp_pkg::OFS_AUX, 32'h0, "aux cleared");
    $display("test results finished");
  endtask

  // Enable low must freeze all state; a reset in mid-run must bring back reset values.
  task automatic test_enable_reset();
    wr(tarp_pkg::OFS_STAT, 32'h2);
    ce        <= 1'b0;
    conv_data <= 12'h777;
    conv_go   <= 2'b01;
    @(posedge sys_clk);
    conv_go   <= 2'b00;
    repeat (3) @(posedge sys_clk);
    chk({31'h0, bat_rdy}, 32'h0, "frozen battery flag");
    ce <= 1'b1;
    rd_chk(tarp_pkg::OFS_BAT, 32'h0, "frozen battery result");
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_chk(tarp_pkg::OFS_SAME, 32'h0, "same interval after reset");
    chk({31'h0, point_ready}, 32'h1, "point ready after reset");
    $display("test enable and reset finished");
  endtask

  task automatic test_touch();
    int n;
    offer(2'h0, 1'b1, 1'b0);
    chk({30'h0, mode}, 32'h0, "mode output");
    rd_chk(tarp_pkg::OFS_TCH, word(12'h456, 12'h123, 1'b0), "two-measure word");
    rd_chk(tarp_pkg::OFS_TCH, 32'h0, "empty fifo read");
    wait_for(0, 1'b1, 10, n);
    offer(2'h1, 1'b1, 1'b1);
    chk({31'h0, drv}, 32'h1, "drive select output");
    chk({30'h0, mode}, 32'h1, "three-measure mode output");
    rd_chk(tarp_pkg::OFS_TCH, word(12'h456, 12'h123, 1'b0), "three-measure first");
    chk({31'h0, point_ready}, 32'h0, "half-read point blocks");
    rd_chk(tarp_pkg::OFS_TCH, word(12'h0, 12'h789, 1'b0), "three-measure second");
    wait_for(0, 1'b1, 10, n);
    for (int p = 0; p < 2; p++) begin
      offer(2'h2, p[0], 1'b0);
      rd_chk(tarp_pkg::OFS_TCH, word(12'h456, 12'h123, p[0]), "four-measure first");
      rd_chk(tarp_pkg::OFS_TCH, word(12'habc, 12'h789, p[0]), "four-measure second");
      wait_for(0, 1'b1, 10, n);
    end
    $display("test touch finished");
  endtask

  task automatic test_filter();
    int n;
    // The pair differs by 12'h333: equal to the threshold passes, one below zeroes the point.
    for (int t = 0; t < 2; t++) begin
      wr(tarp_pkg::OFS_FLT, 32'h0000_8333 - t);
      offer(2'h2, 1'b1, 1'b0);
      rd_chk(tarp_pkg::OFS_TCH, t ? 32'h8000_8000 : word(12'h456, 12'h123, 1'b1),
             "filtered first");
      rd_chk(tarp_pkg::OFS_TCH, t ? 32'h8000_8000 : word(12'habc, 12'h789, 1'b1),
             "filtered second");
    end
    wr(tarp_pkg::OFS_FLT, 32'h0);
    offer(2'h1, 1'b0, 1'b0);
    rd_chk(tarp_pkg::OFS_TCH, word(12'h456, 12'h123, 1'b0), "flush first word");
    wr(tarp_pkg::OFS_TCH, 32'hffff_ffff);
    wait_for(0, 1'b1, 10, n);
    rd_chk(tarp_pkg::OFS_TCH, 32'h0, "flushed fifo");
    $display("test filter finished");
  endtask

  task automatic test_interval();
    int n;
    // One count means two ticks, the first partial, so the wait lies in (400, 800].
    wr(tarp_pkg::OFS_SAME, 32'h1);
    wr(tarp_pkg::OFS_WAIT, 32'h0);
    istart <= 2'b01;
    @(posedge sys_clk);
    istart <= 2'b00;
    wait_for(4, 1'b1, 1000, n);
    chk({31'h0, n > 400 && n <= 802}, 32'h1, "same-point expiry time");
    istart <= 2'b10;
    @(posedge sys_clk);
    istart <= 2'b00;
    wait_for(5, 1'b1, 1000, n);
    chk({31'h0, n <= 402}, 32'h1, "pen-wait expiry time");
    $display("test interval finished");
  endtask

  // Watchdog sized well beyond the few thousand cycles the tests need.
  initial begin
    #(25 * 20000);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    sys_rst   = 1'b1;
    ce        = 1'b1;
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'b00;
    hwrite    = 1'b0;
    hsize     = 3'b010;
    hwdata    = 32'h0;
    send      = 1'b0;
    pt        = '0;
    conv_go   = 2'b00;
    conv_data = 12'h0;
    istart    = 2'b00;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    test_regs();
    test_results();
    test_enable_reset();
    test_touch();
    test_filter();
    test_interval();
    test_done();
  end
endmodule
